// ---- logic/instr_exec_map.svh ----
`ifndef INSTR_EXEC_MAP_SVH
`define INSTR_EXEC_MAP_SVH

// Opcode patterns on the upper bits of the instruction word; watchdog clear matches the whole word
`define OP_AND_LIT 8'hB5
`define OP_AND_REG_HI 7'h05
`define OP_CLR_REG_HI 7'h14
`define OP_BIT_SET_HI 5'h10
`define OP_BIT_CLR_HI 5'h11
`define OP_TEST_ONE_HI 5'h12
`define OP_TEST_ZERO_HI 5'h13
`define OP_BIT_INV_HI 5'h07
`define OP_CALL_HI 3'h7
`define OP_WDT_CLEAR 16'h0004

// Reset values
`define ACC_RESET 8'h00
`define PC_RESET 16'h0000
`define LATCH_RESET 8'h00
`define ZERO_BYTE 8'h00

// Phase encoding of the four-phase instruction cycle
`define PH_Q1 2'h0
`define PH_Q2 2'h1
`define PH_Q3 2'h2
`define PH_Q4 2'h3

`endif

// ---- logic/instr_exec_pkg.sv ----
package instr_exec_pkg;
    // Decoded instruction classes
    typedef enum logic [3:0] {
        OP_NONE,
        OP_AND_LIT,
        OP_AND_REG,
        OP_BIT_CLR,
        OP_BIT_SET,
        OP_BIT_INV,
        OP_TEST_ZERO,
        OP_TEST_ONE,
        OP_CALL,
        OP_CLR_REG,
        OP_WDT_CLR
    } op_t;

    // Execution states
    typedef enum logic [1:0] {
        ST_EXEC,
        ST_SKIP_NOP,
        ST_CALL_NOP
    } exec_state_t;
endpackage

// ---- logic/phase_gen.sv ----
`timescale 1ns/1ps
`include "instr_exec_map.svh"

// Four-phase sequencer: one instruction cycle is four clocks
module phase_gen (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Phase outputs
    output logic [1:0] phase_out,
    output logic cycle_end_out
);
    logic [1:0] phase_q;
    logic [1:0] phase_d;

    // Next phase wraps from the fourth back to the first
    always_comb begin
        phase_d = phase_q;
        if (clk_en_in) begin
            phase_d = phase_q + 2'h1;
        end
    end

    // Phase register
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            phase_q <= `PH_Q1;
        end else begin
            phase_q <= phase_d;
        end
    end

    assign phase_out = phase_q;
    assign cycle_end_out = clk_en_in && (phase_q == `PH_Q4);
endmodule

// ---- logic/logic_bit_call_instr_exec.sv ----
// How it works
// - And-with-literal ANDs the low byte into the accumulator; zero only.
// - And-with-register result goes to acc (d=0) or register; zero only.
// - Bit clear zeroes the selected register bit; nothing else changes.
// - Bit set forces the selected register bit to one; nothing else changes.
// - Bit invert flips the selected register bit in one cycle, no flags.
// - Test-skip-if-zero skips the next word when the selected bit is zero.
// - Test-skip-if-one skips the next word when the selected bit is one.
// - A taken skip drops the prefetched word and adds one idle cycle.
// - Near call loads the 13-bit literal into pc 12:0 and keeps pc 15:13.
// - Near call pushes pc plus one onto the return stack in phase two.
// - After a call the high latch holds literal 12:8 low, pc 15:13 high.
// - Near call takes two cycles, the second idle, with no flag changes.
// - Register clear zeroes the register, and the accumulator too if s=0.
// - Watchdog clear raises the watchdog clear output for one clock.
// - Watchdog clear sets both the timeout and powerdown flags.
`timescale 1ns/1ps
`include "instr_exec_map.svh"

module logic_bit_call_instr_exec (
    // Clock, reset and enable
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Instruction word, valid through the whole cycle
    input wire logic [15:0] instr_word_in,
    // Data memory read port
    output logic [7:0] mem_addr_out,
    input wire logic [7:0] mem_rdata_in,
    // Data memory write port
    output logic mem_we_out,
    output logic [7:0] mem_wdata_out,
    // Architectural state
    output logic [7:0] working_accumulator_out,
    output logic zero_flag_out,
    output logic [15:0] pc_out,
    output logic [7:0] pc_high_latch_out,
    // Return stack push
    output logic stack_push_out,
    output logic [15:0] stack_top_out,
    // Watchdog
    output logic watchdog_clear_out,
    output logic timeout_flag_out,
    output logic powerdown_flag_out,
    // Sequencing
    output logic [1:0] phase_out,
    output logic fetch_discard_out
);
    logic [1:0] phase;
    logic cycle_end;

    logic [7:0] acc_q, acc_d;
    logic zero_q, zero_d;
    logic [15:0] pc_q, pc_d;
    logic [7:0] latch_q, latch_d;
    logic [15:0] instr_q, instr_d;
    logic [7:0] opnd_q, opnd_d;
    logic [7:0] result_q, result_d;
    logic skip_q, skip_d;
    logic we_q, we_d;
    logic push_q, push_d;
    logic [15:0] tos_q, tos_d;
    logic wdt_q, wdt_d;
    logic to_q, to_d;
    logic pd_q, pd_d;
    instr_exec_pkg::op_t op;
    logic [7:0] sel_mask;
    instr_exec_pkg::exec_state_t st_q, st_d;

    // ======================================================
    // Phase sequencer
    phase_gen u_phase (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .phase_out(phase),
        .cycle_end_out(cycle_end)
    );

    // ======================================================
    // Decode helpers
    function automatic instr_exec_pkg::op_t decode_op(
        input logic [15:0] w
    );
        instr_exec_pkg::op_t r;
        r = instr_exec_pkg::OP_NONE;
        if (w == `OP_WDT_CLEAR) begin
            r = instr_exec_pkg::OP_WDT_CLR;
        end else if (w[15:13] == `OP_CALL_HI) begin
            r = instr_exec_pkg::OP_CALL;
        end else if (w[15:8] == `OP_AND_LIT) begin
            r = instr_exec_pkg::OP_AND_LIT;
        end else if (w[15:9] == `OP_AND_REG_HI) begin
            r = instr_exec_pkg::OP_AND_REG;
        end else if (w[15:9] == `OP_CLR_REG_HI) begin
            r = instr_exec_pkg::OP_CLR_REG;
        end else if (w[15:11] == `OP_BIT_CLR_HI) begin
            r = instr_exec_pkg::OP_BIT_CLR;
        end else if (w[15:11] == `OP_BIT_SET_HI) begin
            r = instr_exec_pkg::OP_BIT_SET;
        end else if (w[15:11] == `OP_BIT_INV_HI) begin
            r = instr_exec_pkg::OP_BIT_INV;
        end else if (w[15:11] == `OP_TEST_ZERO_HI) begin
            r = instr_exec_pkg::OP_TEST_ZERO;
        end else if (w[15:11] == `OP_TEST_ONE_HI) begin
            r = instr_exec_pkg::OP_TEST_ONE;
        end
        return r;
    endfunction

    // One-hot mask for the 3-bit bit field
    function automatic logic [7:0] bit_mask(input logic [2:0] b);
        return 8'h01 << b;
    endfunction

    // Operation and bit mask come from the word latched in phase one
    assign op = decode_op(instr_q);
    assign sel_mask = bit_mask(instr_q[10:8]);

    // ======================================================
    // Execution next state
    always_comb begin
        acc_d = acc_q;
        zero_d = zero_q;
        pc_d = pc_q;
        latch_d = latch_q;
        instr_d = instr_q;
        opnd_d = opnd_q;
        result_d = result_q;
        skip_d = skip_q;
        we_d = 1'b0;
        push_d = 1'b0;
        tos_d = tos_q;
        wdt_d = 1'b0;
        to_d = to_q;
        pd_d = pd_q;
        st_d = st_q;
        if (clk_en_in) begin
            case (phase)
                `PH_Q1: begin
                    // Latch only while executing, so an idle cycle ignores
                    // the discarded prefetch
                    if (st_q == instr_exec_pkg::ST_EXEC) begin
                        instr_d = instr_word_in;
                    end else begin
                        instr_d = `PC_RESET; // Idle word decodes as none
                    end
                    skip_d = 1'b0;
                end
                `PH_Q2: begin
                    opnd_d = mem_rdata_in;
                    if (op == instr_exec_pkg::OP_CALL) begin
                        push_d = 1'b1;
                        tos_d = pc_q + 16'h0001;
                    end
                end
                `PH_Q3: begin
                    // Compute in phase three
                    case (op)
                        instr_exec_pkg::OP_AND_LIT: begin
                            result_d = acc_q & instr_q[7:0];
                        end
                        instr_exec_pkg::OP_AND_REG: begin
                            result_d = acc_q & opnd_q;
                        end
                        instr_exec_pkg::OP_BIT_CLR: begin
                            result_d = opnd_q & ~sel_mask;
                        end
                        instr_exec_pkg::OP_BIT_SET: begin
                            result_d = opnd_q | sel_mask;
                        end
                        instr_exec_pkg::OP_BIT_INV: begin
                            result_d = opnd_q ^ sel_mask;
                        end
                        instr_exec_pkg::OP_TEST_ZERO: begin
                            skip_d = ~|(opnd_q & sel_mask);
                        end
                        instr_exec_pkg::OP_TEST_ONE: begin
                            skip_d = |(opnd_q & sel_mask);
                        end
                        instr_exec_pkg::OP_CLR_REG: begin
                            result_d = `ZERO_BYTE;
                        end
                        default: result_d = result_q;
                    endcase
                end
                default: begin
                    // Phase four: write destination and advance
                    pc_d = pc_q + 16'h0001;
                    st_d = instr_exec_pkg::ST_EXEC;
                    case (op)
                        instr_exec_pkg::OP_AND_LIT: begin
                            acc_d = result_q;
                            zero_d = (result_q == `ZERO_BYTE);
                        end
                        instr_exec_pkg::OP_AND_REG: begin
                            zero_d = (result_q == `ZERO_BYTE);
                            if (instr_q[8]) begin
                                we_d = 1'b1;
                            end else begin
                                acc_d = result_q;
                            end
                        end
                        instr_exec_pkg::OP_BIT_CLR,
                        instr_exec_pkg::OP_BIT_SET,
                        instr_exec_pkg::OP_BIT_INV: begin
                            we_d = 1'b1;
                        end
                        instr_exec_pkg::OP_CLR_REG: begin
                            we_d = 1'b1;
                            if (!instr_q[8]) begin
                                acc_d = `ZERO_BYTE;
                            end
                        end
                        instr_exec_pkg::OP_TEST_ZERO,
                        instr_exec_pkg::OP_TEST_ONE: begin
                            if (skip_q) begin
                                st_d = instr_exec_pkg::ST_SKIP_NOP;
                            end
                        end
                        instr_exec_pkg::OP_CALL: begin
                            pc_d = {pc_q[15:13], instr_q[12:0]};
                            latch_d = {pc_q[15:13], instr_q[12:8]};
                            st_d = instr_exec_pkg::ST_CALL_NOP;
                        end
                        instr_exec_pkg::OP_WDT_CLR: begin
                            wdt_d = 1'b1;
                            to_d = 1'b1;
                            pd_d = 1'b1;
                        end
                        default: begin
                            st_d = instr_exec_pkg::ST_EXEC;
                        end
                    endcase
                    // The idle cycle after a call does not step the pc
                    if (st_q == instr_exec_pkg::ST_CALL_NOP) begin
                        pc_d = pc_q;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // Registers
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_q <= `ACC_RESET;
            zero_q <= 1'b0;
            pc_q <= `PC_RESET;
            latch_q <= `LATCH_RESET;
            instr_q <= `PC_RESET;
            opnd_q <= `ZERO_BYTE;
            result_q <= `ZERO_BYTE;
            skip_q <= 1'b0;
            we_q <= 1'b0;
            push_q <= 1'b0;
            tos_q <= `PC_RESET;
            wdt_q <= 1'b0;
            to_q <= 1'b1;
            pd_q <= 1'b1;
            st_q <= instr_exec_pkg::ST_EXEC;
        end else begin
            acc_q <= acc_d;
            zero_q <= zero_d;
            pc_q <= pc_d;
            latch_q <= latch_d;
            instr_q <= instr_d;
            opnd_q <= opnd_d;
            result_q <= result_d;
            skip_q <= skip_d;
            we_q <= we_d;
            push_q <= push_d;
            tos_q <= tos_d;
            wdt_q <= wdt_d;
            to_q <= to_d;
            pd_q <= pd_d;
            st_q <= st_d;
        end
    end

    // ======================================================
    // Outputs; the address follows the latched word's low byte
    assign mem_addr_out = instr_q[7:0];
    assign mem_we_out = we_q;
    assign mem_wdata_out = result_q;
    assign working_accumulator_out = acc_q;
    assign zero_flag_out = zero_q;
    assign pc_out = pc_q;
    assign pc_high_latch_out = latch_q;
    assign stack_push_out = push_q;
    assign stack_top_out = tos_q;
    assign watchdog_clear_out = wdt_q;
    assign timeout_flag_out = to_q;
    assign powerdown_flag_out = pd_q;
    assign phase_out = phase;
    // High through any idle cycle: the fetched word is not executed
    assign fetch_discard_out = (st_q != instr_exec_pkg::ST_EXEC);
endmodule

// ---- verification/logic_bit_call_instr_exec_properties.sv ----
`timescale 1ns/1ps
`include "instr_exec_map.svh"

module logic_bit_call_instr_exec_properties (
    // Clock, reset and enable
    input wire logic clk_sys_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // Watched ports
    input wire logic [15:0] instr_word_in,
    input wire logic mem_we_out,
    input wire logic zero_flag_out,
    input wire logic [15:0] pc_out,
    input wire logic [7:0] pc_high_latch_out,
    input wire logic stack_push_out,
    input wire logic [15:0] stack_top_out,
    input wire logic watchdog_clear_out,
    input wire logic timeout_flag_out,
    input wire logic powerdown_flag_out,
    input wire logic [1:0] phase_out,
    input wire logic fetch_discard_out
);
    logic take;
    logic [15:0] word_q;
    logic [15:0] pc_cap_q;

    // ==========================================================
    // Capture of the accepted word
    assign take = clk_en_in && phase_out == 2'h0 && !fetch_discard_out;

    // Results land four enabled clocks later, so keep word and address
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            word_q <= 16'h0000;
            pc_cap_q <= 16'h0000;
        end else if (take) begin
            word_q <= instr_word_in;
            pc_cap_q <= pc_out;
        end
    end

    // ==========================================================
    // Properties
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    sequence call_take;
        take && instr_word_in[15:13] == `OP_CALL_HI;
    endsequence

    sequence call_cycle;
        call_take ##1 clk_en_in [*3];
    endsequence

    sequence wdt_cycle;
        take && instr_word_in == `OP_WDT_CLEAR ##1 clk_en_in [*3];
    endsequence

    a_phase_step: assert property (
        clk_en_in |=> phase_out == $past(phase_out) + 2'h1)
        else $error("phase did not advance by one");
    a_write_after_q4: assert property (
        mem_we_out |-> phase_out == 2'h0 && $past(phase_out) == 2'h3)
        else $error("write strobe outside the fourth phase");
    a_push_in_q2: assert property (
        stack_push_out |-> phase_out == 2'h2
            && stack_top_out == pc_out + 16'h0001)
        else $error("push late or wrong return address");
    a_call_target: assert property (
        call_cycle |=> pc_out == {pc_cap_q[15:13], word_q[12:0]})
        else $error("call target wrong");
    a_call_latch: assert property (
        call_cycle |=> pc_high_latch_out
            == {pc_cap_q[15:13], word_q[12:8]})
        else $error("high latch wrong after call");
    a_call_idle: assert property (
        call_cycle |=> fetch_discard_out [*4])
        else $error("call second cycle not idle");
    a_idle_no_write: assert property (
        fetch_discard_out |-> !mem_we_out)
        else $error("write during idle cycle");
    a_wdt_clear: assert property (
        wdt_cycle |=> watchdog_clear_out)
        else $error("watchdog clear missing");
    a_wdt_flags: assert property (
        watchdog_clear_out |-> timeout_flag_out && powerdown_flag_out)
        else $error("status flags not set by watchdog clear");
    a_zero_cause: assert property (
        $changed(zero_flag_out) |-> $past(phase_out) == 2'h3
            && (word_q[15:8] == `OP_AND_LIT
            || word_q[15:9] == `OP_AND_REG_HI))
        else $error("zero flag changed by other instruction");
    a_push_on_call: assert property (
        call_take ##1 clk_en_in |=> stack_push_out)
        else $error("no push in a call cycle");
    a_enable_freeze: assert property (
        !clk_en_in |=> $stable(phase_out) && $stable(pc_out)
            && $stable(pc_high_latch_out))
        else $error("state moved while the enable was low");
endmodule

bind logic_bit_call_instr_exec logic_bit_call_instr_exec_properties i_props (
    .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in), .instr_word_in(instr_word_in),
    .mem_we_out(mem_we_out), .zero_flag_out(zero_flag_out),
    .pc_out(pc_out), .pc_high_latch_out(pc_high_latch_out),
    .stack_push_out(stack_push_out), .stack_top_out(stack_top_out),
    .watchdog_clear_out(watchdog_clear_out),
    .timeout_flag_out(timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out),
    .phase_out(phase_out), .fetch_discard_out(fetch_discard_out)
);

// ---- verification/logic_bit_call_instr_exec_tb.sv ----
`timescale 1ns/1ps

module logic_bit_call_instr_exec_tb;
    // ==========================================================
    // Signals
    logic clk_sys_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [15:0] instr_word_in = 16'h0000;
    logic [7:0] mem_rdata_in = 8'h00;
    logic [7:0] mem_addr_out, mem_wdata_out, acc, latch;
    logic mem_we_out, zero_flag_out, stack_push_out, wdt_clr;
    logic timeout_flag_out, powerdown_flag_out, fetch_discard_out;
    logic [15:0] pc_out, stack_top_out, pc_e;
    logic [1:0] phase_out;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    logic_bit_call_instr_exec i_logic_bit_call_instr_exec (
        .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in), .instr_word_in(instr_word_in),
        .mem_addr_out(mem_addr_out), .mem_rdata_in(mem_rdata_in),
        .mem_we_out(mem_we_out), .mem_wdata_out(mem_wdata_out),
        .working_accumulator_out(acc), .zero_flag_out(zero_flag_out),
        .pc_out(pc_out), .pc_high_latch_out(latch),
        .stack_push_out(stack_push_out), .stack_top_out(stack_top_out),
        .watchdog_clear_out(wdt_clr), .timeout_flag_out(timeout_flag_out),
        .powerdown_flag_out(powerdown_flag_out), .phase_out(phase_out),
        .fetch_discard_out(fetch_discard_out)
    );

    // ==========================================================
    // Tasks
    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        if (fails == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One instruction cycle, entered and left at the falling edge in Q1
    task automatic run(input logic [15:0] w, input logic [7:0] rd);
        instr_word_in = w;
        mem_rdata_in = rd;
        repeat (4) @(negedge clk_sys_in);
        pc_e = pc_e + 16'h0001;
    endtask

    // A register write; the strobe is only one clock, so look at once
    task automatic wr(input logic [15:0] w, input logic [7:0] rd,
                      input logic [7:0] wd);
        run(w, rd);
        check("strobe", {15'h0, mem_we_out}, 16'h0001);
        check("wdata", {8'h0, mem_wdata_out}, {8'h0, wd});
        check("addr", {8'h0, mem_addr_out}, {8'h0, w[7:0]});
    endtask

    // Hang guard: the whole sequence needs well under 400 clocks
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            close_out();
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [7:0] mask;
        pc_e = 16'h0000;
        repeat (3) @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        check("acc", {8'h0, acc}, 16'h0000);
        check("pc", pc_out, 16'h0000);
        check("latch", {8'h0, latch}, 16'h0000);
        check("to pd", {14'h0, timeout_flag_out, powerdown_flag_out},
              16'h0003);
        // Unknown word acts as a no-op
        run(16'h4C12, 8'hFF);
        check("nop strobe", {15'h0, mem_we_out}, 16'h0000);
        // Every bit position of set, clear and invert
        for (int b = 0; b < 8; b++) begin
            mask = 8'h01 << b;
            wr({5'h10, b[2:0], 8'h3C}, 8'h5A, 8'h5A | mask);
            wr({5'h11, b[2:0], 8'h3D}, 8'h5A, 8'h5A & ~mask);
            wr({5'h07, b[2:0], 8'h3E}, 8'h5A, 8'h5A ^ mask);
        end
        check("zero", {15'h0, zero_flag_out}, 16'h0000);
        wr(16'h2933, 8'hFF, 8'h00);
        wr(16'h2832, 8'hFF, 8'h00);
        check("zero", {15'h0, zero_flag_out}, 16'h0000);
        run(16'hB5FF, 8'h00);
        check("and zero", {7'h0, acc, zero_flag_out}, 16'h0001);
        wr(16'h0B44, 8'hFF, 8'h00);
        run(16'h0A44, 8'hFF);
        check("and to acc", {7'h0, acc, mem_we_out}, 16'h0000);
        // Both bit tests with the bit low and high
        for (int k = 0; k < 4; k++) begin
            mask = 8'h01 << (k + 3);
            run({k[1] ? 5'h12 : 5'h13, 3'(k + 3), 8'h20},
                (k[0] ^ k[1]) ? mask : ~mask);
            check("skip", {15'h0, fetch_discard_out},
                  {15'h0, ~k[0]});
            if (!k[0]) begin
                run(16'h8711, 8'h00);
                check("idle", {15'h0, mem_we_out}, 16'h0000);
            end
            check("pc", pc_out, pc_e);
        end
        // Enable low in the read phase: a stall must not lose the word
        instr_word_in = 16'h8155;
        mem_rdata_in = 8'h00;
        @(negedge clk_sys_in);
        clk_en_in = 1'b0;
        repeat (3) @(negedge clk_sys_in);
        check("frozen phase", {14'h0, phase_out}, 16'h0001);
        check("frozen pc", pc_out, pc_e);
        clk_en_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        pc_e = pc_e + 16'h0001;
        check("late strobe", {15'h0, mem_we_out}, 16'h0001);
        check("late wdata", {8'h0, mem_wdata_out}, 16'h0002);
        check("pc", pc_out, pc_e);
        // Near call, then its idle cycle
        run({3'h7, 13'h1ABC}, 8'h00);
        pc_e = pc_e - 16'h0001;
        check("call pc", pc_out, {pc_e[15:13], 13'h1ABC});
        check("latch", {8'h0, latch},
              {8'h0, pc_e[15:13], 5'h1A});
        check("ret", stack_top_out, pc_e + 16'h0001);
        check("idle", {15'h0, fetch_discard_out}, 16'h0001);
        pc_e = {pc_e[15:13], 13'h1ABC};
        run(16'h2800, 8'h00);
        check("idle we", {15'h0, mem_we_out}, 16'h0000);
        check("held pc", pc_out, pc_e - 16'h0001);
        pc_e = pc_e - 16'h0001;
        run(16'h0004, 8'h00);
        check("wdt", {15'h0, wdt_clr}, 16'h0001);
        check("to pd", {14'h0, timeout_flag_out, powerdown_flag_out},
              16'h0003);
        check("pc", pc_out, pc_e);
        close_out();
    end
endmodule
